// File: rtl/rapc_top.sv
// Register pointer access engine for the host control port, with power register
`timescale 1ns/10ps
`default_nettype none
module rapc_top
  import rapc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic XFER_START,
  input wire logic XFER_READ,
  input wire logic XFER_STOP,
  input wire logic BYTE_RX_VALID,
  input wire logic [7:0] BYTE_RX_DATA,
  input wire logic BYTE_REQ,
  output logic ACK,
  output logic NACK,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic SLEEP,
  output logic PLL_RUN,
  output logic OVS_ON,
  output logic [5:0] DAC_ON
);
  import rapc_pkg::*;

  rapc_state_t state_q, state_d;
  logic [7:0] ptr_q, ptr_d;
  logic ack_q, ack_d, nack_q, nack_d, rdv_q, rdv_d;
  logic [7:0] rdd_q, rdd_d;
  logic [5:0] dac_on;
  logic pll_run, ovs_on, sleep;

  rapc_reg_if rbus ();

  rapc_power_reg u_pwr (
    .clk(MCLK),
    .rst(RST),
    .bus(rbus),
    .dac_on_q(dac_on),
    .pll_run_q(pll_run),
    .ovs_on_q(ovs_on),
    .sleep_q(sleep)
  );

  // Map read of a valid address; unmapped holes read as a fixed value
  function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] pwr);
    reg_read = (addr == PWR_ADDR) ? pwr : RD_IDLE;
  endfunction : reg_read

  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = (p == PTR_MAX) ? PTR_MAX : p + 8'h01;
  endfunction : ptr_next

  always_comb
  begin
    state_d = state_q;
    ptr_d = ptr_q;
    ack_d = 1'b0;
    nack_d = 1'b0;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    rbus.wr_en = 1'b0;
    rbus.wr_data = BYTE_RX_DATA;
    if (XFER_STOP)
    begin
      state_d = S_IDLE;
    end
    else if (XFER_START)
    begin
      if (state_q == S_PTR)
        state_d = S_IDLE;
      else
        state_d = XFER_READ ? S_RD : S_PTR;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          state_d = S_IDLE;
        end
        S_PTR:
        begin
          if (BYTE_RX_VALID)
          begin
            if (BYTE_RX_DATA > LAST_ADDR)
            begin
              nack_d = 1'b1;
              state_d = S_IDLE;
            end
            else
            begin
              ptr_d = BYTE_RX_DATA;
              ack_d = 1'b1;
              state_d = S_WR;
            end
          end
        end
        S_WR:
        begin
          if (BYTE_RX_VALID)
          begin
            if (ptr_q > LAST_ADDR)
            begin
              nack_d = 1'b1;
              state_d = S_IDLE;
            end
            else
            begin
              rbus.wr_en = (ptr_q == PWR_ADDR);
              ack_d = 1'b1;
              ptr_d = ptr_next(ptr_q);
            end
          end
        end
        S_RD:
        begin
          if (BYTE_REQ)
          begin
            rdv_d = 1'b1;
            rdd_d = reg_read((ptr_q > LAST_ADDR) ? LAST_ADDR : ptr_q, rbus.pwr);
            ptr_d = ptr_next(ptr_q);
          end
        end
        default:
        begin
          state_d = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= S_IDLE;
      ptr_q <= PTR_RESET;
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      rdv_q <= 1'b0;
      rdd_q <= RD_IDLE;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      ack_q <= ack_d;
      nack_q <= nack_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
    end
  end

  assign ACK = ack_q;
  assign NACK = nack_q;
  assign RD_VALID = rdv_q;
  assign RD_DATA = rdd_q;
  assign SLEEP = sleep;
  assign PLL_RUN = pll_run;
  assign OVS_ON = ovs_on;
  assign DAC_ON = dac_on;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  property p_stop_idle;
    XFER_STOP |=> state_q == S_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not force idle");

  property p_bad_ptr;
    state_q == S_PTR && !XFER_STOP && !XFER_START && BYTE_RX_VALID && BYTE_RX_DATA > LAST_ADDR
      |=> NACK && !ACK && state_q == S_IDLE;
  endproperty
  a_bad_ptr: assert property (p_bad_ptr) else $error("invalid pointer was acknowledged");

  property p_wr_inc;
    state_q == S_WR && !XFER_STOP && !XFER_START && BYTE_RX_VALID && ptr_q <= LAST_ADDR
      |=> ACK && ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_wr_inc: assert property (p_wr_inc) else $error("pointer did not advance on write");

  property p_wr_over;
    state_q == S_WR && !XFER_STOP && !XFER_START && BYTE_RX_VALID && ptr_q > LAST_ADDR
      |=> NACK && state_q == S_IDLE && $stable(rbus.pwr);
  endproperty
  a_wr_over: assert property (p_wr_over) else $error("write past top not refused");

  property p_wr_store;
    state_q == S_WR && !XFER_STOP && !XFER_START && BYTE_RX_VALID && ptr_q == PWR_ADDR
      |=> rbus.pwr == $past(BYTE_RX_DATA);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("write lost, even in sleep");

  property p_rd_data;
    state_q == S_RD && !XFER_STOP && !XFER_START && BYTE_REQ
      |=> RD_VALID && RD_DATA == reg_read(LAST_ADDR, $past(rbus.pwr));
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read returned wrong register");

  property p_ptr_first;
    state_q == S_PTR && !XFER_STOP && !XFER_START && BYTE_RX_VALID && BYTE_RX_DATA <= LAST_ADDR
      |=> ACK && ptr_q == $past(BYTE_RX_DATA) && state_q == S_WR;
  endproperty
  a_ptr_first: assert property (p_ptr_first) else $error("pointer byte not loaded");

  c_write: cover property (state_q == S_WR && BYTE_RX_VALID ##1 ACK);
  c_read_over: cover property (state_q == S_RD && BYTE_REQ ##1 RD_VALID ##2 RD_VALID);
  c_nack: cover property (NACK);
endmodule : rapc_top
`default_nettype wire

// File: pkg/rapc_pkg.sv
// Constants and types for the register access and power control block
`default_nettype none
package rapc_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_DAC = 6;
  localparam logic [7:0] PWR_ADDR = 8'h00;
  localparam logic [7:0] LAST_ADDR = 8'h00;
  localparam logic [7:0] PWR_RESET = 8'h12;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_MAX = 8'hFF;
  localparam logic [7:0] RD_IDLE = 8'h00;
  localparam int unsigned SLEEP_BIT = 0;
  localparam int unsigned PLL_OFF_BIT = 1;
  localparam int unsigned DAC3_BIT = 2;
  localparam int unsigned DAC2_BIT = 3;
  localparam int unsigned DAC1_BIT = 4;
  localparam int unsigned DAC6_BIT = 5;
  localparam int unsigned DAC5_BIT = 6;
  localparam int unsigned DAC4_BIT = 7;
  typedef enum logic [1:0] {S_IDLE, S_PTR, S_WR, S_RD} rapc_state_t;
endpackage : rapc_pkg
`default_nettype wire

// File: pkg/rapc_reg_if.sv
// Write path and read-back between the access engine and the power register
`timescale 1ns/10ps
`default_nettype none
interface rapc_reg_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] pwr;
  modport ctl (output wr_en, output wr_data, input pwr);
  modport regs (input wr_en, input wr_data, output pwr);
endinterface : rapc_reg_if
`default_nettype wire

// File: rtl/rapc_power_reg.sv
// Power control register and its decoded power outputs
`timescale 1ns/10ps
`default_nettype none
module rapc_power_reg
  import rapc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  rapc_reg_if.regs bus,
  output logic [5:0] dac_on_q,
  output logic pll_run_q,
  output logic ovs_on_q,
  output logic sleep_q
);
  import rapc_pkg::*;

  logic [7:0] pwr_q, pwr_d;
  logic [5:0] dac_on_d;
  logic pll_run_d, ovs_on_d, sleep_d;

  // Index 0..5 is DAC 1..6
  function automatic logic [5:0] dac_map(input logic [7:0] p);
    dac_map = {p[DAC6_BIT], p[DAC5_BIT], p[DAC4_BIT], p[DAC3_BIT], p[DAC2_BIT], p[DAC1_BIT]};
  endfunction : dac_map

  assign bus.pwr = pwr_q;

  always_comb
  begin
    pwr_d = bus.wr_en ? bus.wr_data : pwr_q;
    sleep_d = pwr_q[SLEEP_BIT];
    dac_on_d = pwr_q[SLEEP_BIT] ? 6'h00 : dac_map(pwr_q);
    pll_run_d = ~pwr_q[SLEEP_BIT] & ~pwr_q[PLL_OFF_BIT];
    ovs_on_d = ~pwr_q[SLEEP_BIT] & ~pwr_q[PLL_OFF_BIT];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_q <= PWR_RESET;
      dac_on_q <= 6'h00;
      pll_run_q <= 1'b0;
      ovs_on_q <= 1'b0;
      sleep_q <= 1'b0;
    end
    else
    begin
      pwr_q <= pwr_d;
      dac_on_q <= dac_on_d;
      pll_run_q <= pll_run_d;
      ovs_on_q <= ovs_on_d;
      sleep_q <= sleep_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_value;
    @(posedge clk) disable iff (1'b0) rst |=> (pwr_q == PWR_RESET) || bus.wr_en;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("power reset value wrong");

  property p_sleep_off;
    pwr_q[SLEEP_BIT] |=> dac_on_q == 6'h00 && !pll_run_q && sleep_q;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left a DAC or PLL on");

  property p_pll_off;
    pwr_q[PLL_OFF_BIT] |=> !pll_run_q && !ovs_on_q;
  endproperty
  a_pll_off: assert property (p_pll_off) else $error("PLL or oversampling still on");

  property p_dac_low;
    !pwr_q[SLEEP_BIT] |=> dac_on_q[2:0] == {$past(pwr_q[DAC3_BIT]), $past(pwr_q[DAC2_BIT]),
      $past(pwr_q[DAC1_BIT])};
  endproperty
  a_dac_low: assert property (p_dac_low) else $error("DAC 1-3 enable mismatch");

  property p_dac_high;
    !pwr_q[SLEEP_BIT] |=> dac_on_q[5:3] == {$past(pwr_q[DAC6_BIT]), $past(pwr_q[DAC5_BIT]),
      $past(pwr_q[DAC4_BIT])};
  endproperty
  a_dac_high: assert property (p_dac_high) else $error("DAC 4-6 enable mismatch");

  c_sleep: cover property (!pwr_q[SLEEP_BIT] ##1 pwr_q[SLEEP_BIT]);
endmodule : rapc_power_reg
`default_nettype wire

// File: test/rapc_host_model.sv
// Host model driving the byte-level strobes of the control port
`timescale 1ns/10ps
`default_nettype none
module rapc_host_model
(
  input wire logic clk,
  input wire logic ack,
  input wire logic nack,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic start,
  output logic rd,
  output logic stop,
  output logic bvalid,
  output logic [7:0] bdata,
  output logic breq
);
  initial
  begin
    {start, rd, stop, bvalid, breq} = 5'h00;
    bdata = 8'h5A;
  end
  task automatic begin_xfer(input logic r);
    @(posedge clk);
    #1 start = 1'b1;
    rd = r;
    @(posedge clk);
    #1 start = 1'b0;
    rd = ~r;
  endtask : begin_xfer
  task automatic end_xfer();
    @(posedge clk);
    #1 stop = 1'b1;
    @(posedge clk);
    #1 stop = 1'b0;
  endtask : end_xfer
  // Released data line shows the inverse
  task automatic send(input logic [7:0] b, output logic a, output logic n);
    @(posedge clk);
    #1 bvalid = 1'b1;
    bdata = b;
    @(posedge clk);
    #1 bvalid = 1'b0;
    bdata = ~b;
    a = ack;
    n = nack;
  endtask : send
  task automatic req(output logic v, output logic [7:0] d);
    @(posedge clk);
    #1 breq = 1'b1;
    @(posedge clk);
    #1 breq = 1'b0;
    v = rd_valid;
    d = rd_data;
  endtask : req
  // Result bits: pointer ack, pointer nack, data ack, data nack
  task automatic write_reg(input logic [7:0] p, input logic [7:0] v, output logic [3:0] r);
    begin_xfer(1'b0);
    send(p, r[3], r[2]);
    send(v, r[1], r[0]);
    end_xfer();
  endtask : write_reg
endmodule : rapc_host_model
`default_nettype wire

// File: test/rapc_top_tb_top.sv
// Self-checking bench for the register access and power control block
`timescale 1ns/10ps
`default_nettype none
module rapc_top_tb_top;
  import rapc_pkg::*;
  logic MCLK;
  logic RST;
  logic st, rd, sp, bv, bq, ack, nack, rv, slp, pll, ovs, a, n, v;
  logic [7:0] bd, rdd, d;
  logic [5:0] dac;
  logic [3:0] r;
  logic [7:0] vals [5] = '{8'h00, 8'hFC, 8'h1D, 8'hE3, 8'h02};
  int n_errors = 0;
  int tests_run = 0;
  rapc_top rapc_top_inst (.MCLK(MCLK), .RST(RST), .XFER_START(st), .XFER_READ(rd),
    .XFER_STOP(sp), .BYTE_RX_VALID(bv), .BYTE_RX_DATA(bd), .BYTE_REQ(bq), .ACK(ack),
    .NACK(nack), .RD_VALID(rv), .RD_DATA(rdd), .SLEEP(slp), .PLL_RUN(pll),
    .OVS_ON(ovs), .DAC_ON(dac));
  rapc_host_model rapc_host_model_inst (.clk(MCLK), .ack(ack), .nack(nack), .rd_valid(rv),
    .rd_data(rdd), .start(st), .rd(rd), .stop(sp), .bvalid(bv), .bdata(bd), .breq(bq));
  initial
  begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic tally_and_finish();
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h got %h", s, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic rd_pwr(input logic [7:0] e);
    rapc_host_model_inst.begin_xfer(1'b1);
    rapc_host_model_inst.req(v, d);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk("rd_data", e, d);
    rapc_host_model_inst.end_xfer();
  endtask : rd_pwr
  task automatic chk_pwr(input logic [7:0] p);
    logic run;
    run = ~p[SLEEP_BIT] & ~p[PLL_OFF_BIT];
    repeat (2) @(posedge MCLK);
    #1;
    chk("sleep", {7'h00, p[SLEEP_BIT]}, {7'h00, slp});
    chk("pll_run", {7'h00, run}, {7'h00, pll});
    chk("ovs_on", {7'h00, run}, {7'h00, ovs});
    chk("dac_on", {2'h0, p[SLEEP_BIT] ? 6'h00 : {p[DAC6_BIT], p[DAC5_BIT], p[DAC4_BIT],
      p[DAC3_BIT], p[DAC2_BIT], p[DAC1_BIT]}}, {2'h0, dac});
    rd_pwr(p);
  endtask : chk_pwr
  initial
  begin
    for (int i = 0; i < 5000; i++)
      @(posedge MCLK);
    n_errors++;
    $display("CHECK FAILED run time expected done got timeout");
    tally_and_finish();
  end
  initial
  begin
    RST = 1'b1;
    repeat (12) @(posedge MCLK);
    #1 RST = 1'b0;
    chk_pwr(PWR_RESET);
    $display("test reset done");
    foreach (vals[i])
    begin
      rapc_host_model_inst.write_reg(PWR_ADDR, vals[i], r);
      chk("write acks", 8'h0A, {4'h0, r});
      chk_pwr(vals[i]);
    end
    $display("test power bits done");
    rapc_host_model_inst.write_reg(8'h05, 8'h77, r);
    chk("bad pointer", 8'h04, {4'h0, r});
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.send(PWR_ADDR, a, n);
    rapc_host_model_inst.send(8'h3C, a, n);
    rapc_host_model_inst.send(8'h99, a, n);
    chk("past top write", 8'h01, {6'h00, a, n});
    rapc_host_model_inst.end_xfer();
    chk_pwr(8'h3C);
    $display("test pointer done");
    rapc_host_model_inst.begin_xfer(1'b1);
    repeat (3)
    begin
      rapc_host_model_inst.req(v, d);
      chk("past top read", 8'h3C, d);
      chk("past top valid", 8'h01, {7'h00, v});
    end
    rapc_host_model_inst.end_xfer();
    $display("test read clamp done");
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.send(PWR_ADDR, a, n);
    chk("restart idle", 8'h00, {6'h00, a, n});
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.send(PWR_ADDR, a, n);
    rapc_host_model_inst.end_xfer();
    rapc_host_model_inst.send(8'h55, a, n);
    chk("stop idle", 8'h00, {6'h00, a, n});
    chk_pwr(8'h3C);
    $display("test out of sequence done");
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.send(PWR_ADDR, a, n);
    rapc_host_model_inst.send(8'h81, a, n);
    rapc_host_model_inst.begin_xfer(1'b0);
    rapc_host_model_inst.send(PWR_ADDR, a, n);
    chk("restart pointer", 8'h02, {6'h00, a, n});
    rapc_host_model_inst.begin_xfer(1'b1);
    rapc_host_model_inst.req(v, d);
    chk("restart rd_valid", 8'h01, {7'h00, v});
    chk("restart rd_data", 8'h81, d);
    rapc_host_model_inst.end_xfer();
    $display("test repeated start done");
    @(posedge MCLK);
    #1 RST = 1'b1;
    repeat (3) @(posedge MCLK);
    #1 RST = 1'b0;
    chk_pwr(PWR_RESET);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule : rapc_top_tb_top
`default_nettype wire
